/* amc_mode_ctrl.sv */
// Mode control of a 16-bit converter: config word, serial port, sequencer.
// Assumes analogue results arrive on the core clock; serial pins are async.
// How it works
// - Gain field picks one of six spans
// - LSB size equals span over 32768
// - Timing from 1 MHz tick, no clock pin
// - Temp select bit measures the sensor instead
// - Temp result left-justified, MSB byte first
// - Temp code twos complement, 0.03125 C step
// - Reset reloads every config bit default
// - Start-up rests powered down, logic alive
// - Mode one means single-shot with power-down
// - Serial writes accepted while powered down
// - Start bit powers up, clears, converts once
// - Single-shot powers down after result ready
// - Start bit during conversion is ignored
// - Mode zero converts back to back
// - Mode one or reset leaves continuous
// - 860 SPS conversion lasts about 1.2 ms
// - Serial port carries reads, writes, control
// - Sample input on fall, shift on rise
// - Ready low on result, early high unread in mode zero
// - Input results saturate at full scale
// - Chip select high resets port, floats output
`include "amc_regs.svh"

module amc_mode_ctrl
  import amc_pkg::*;
#(
  parameter int P_OSC_DIV = `AMC_OSC_DIV
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Serial pins from the host
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_din,
  // Combined data and ready pin
  output logic o_serial_out_result_ready,
  output logic o_serial_out_result_ready_oe,
  output logic o_sout_pullup_en,
  // Analogue front end results
  input wire logic [17:0] i_mod_result,
  input wire logic [13:0] i_temp_code,
  // Analogue front end control
  output logic [2:0] o_gain_range_select,
  output logic [12:0] o_full_scale_span,
  output logic [27:0] o_lsb_size_pv,
  output logic [2:0] o_input_mux,
  output logic o_temp_sensor_select,
  output logic o_powered_up,
  output logic o_conv_done
);

  // Data rate code to oscillator ticks per conversion
  function automatic logic [16:0] rate_ticks(input logic [2:0] rate);
    case (rate)
      3'h0: rate_ticks = `AMC_TICKS_8SPS;
      3'h1: rate_ticks = `AMC_TICKS_16SPS;
      3'h2: rate_ticks = `AMC_TICKS_32SPS;
      3'h3: rate_ticks = `AMC_TICKS_64SPS;
      3'h4: rate_ticks = `AMC_TICKS_128SPS;
      3'h5: rate_ticks = `AMC_TICKS_250SPS;
      3'h6: rate_ticks = `AMC_TICKS_475SPS;
      default: rate_ticks = `AMC_TICKS_860SPS;
    endcase
  endfunction : rate_ticks

  // Gain code to span; the two top codes alias the narrowest span
  function automatic logic [12:0] gain_span(input logic [2:0] gain);
    case (gain)
      3'h0: gain_span = `AMC_SPAN_6144MV;
      3'h1: gain_span = `AMC_SPAN_4096MV;
      3'h2: gain_span = `AMC_SPAN_2048MV;
      3'h3: gain_span = `AMC_SPAN_1024MV;
      3'h4: gain_span = `AMC_SPAN_512MV;
      default: gain_span = `AMC_SPAN_256MV;
    endcase
  endfunction : gain_span

  // Clip a wide filter output into 16-bit twos complement
  function automatic logic [15:0] sat16(input logic [17:0] raw);
    if (!raw[17] && (raw[16:15] != 2'h0))
      sat16 = `AMC_CODE_POS_FULL;
    else if (raw[17] && (raw[16:15] != 2'h3))
      sat16 = `AMC_CODE_NEG_FULL;
    else
      sat16 = raw[15:0];
  endfunction : sat16

  // ---------------- Config word and analogue control ----------------
  amc_cfg_t cfg_r;
  amc_cfg_t cfg_wr_word;
  logic cfg_wr;

  // Span and LSB size follow the gain field
  assign o_gain_range_select = cfg_r.gain;
  assign o_full_scale_span = gain_span(cfg_r.gain);
  assign o_lsb_size_pv = 28'(o_full_scale_span[12:8] * `AMC_LSB_PV_PER_256MV);
  assign o_input_mux = cfg_r.mux;
  assign o_sout_pullup_en = cfg_r.pullup_en;

  // Writes land in any state; the start bit is never stored as 1
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      cfg_r <= amc_cfg_t'(`AMC_CFG_RESET);
    else if (cfg_wr)
    begin
      cfg_r <= cfg_wr_word;
      cfg_r.ss <= 1'h0;
    end
  end

  // ---------------- Pin synchronisers ----------------
  logic cs_s1_r, cs_s2_r;
  logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
  logic din_s1_r, din_s2_r;

  // Two flops per pin; the third sclk flop only feeds edge detection
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      cs_s1_r <= 1'h1;
      cs_s2_r <= 1'h1;
      sclk_s1_r <= 1'h0;
      sclk_s2_r <= 1'h0;
      sclk_s3_r <= 1'h0;
      din_s1_r <= 1'h0;
      din_s2_r <= 1'h0;
    end
    else
    begin
      cs_s1_r <= i_cs_n;
      cs_s2_r <= cs_s1_r;
      sclk_s1_r <= i_sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      din_s1_r <= i_din;
      din_s2_r <= din_s1_r;
    end
  end

  wire frame_on = ~cs_s2_r;
  wire sclk_rise = frame_on & sclk_s2_r & ~sclk_s3_r;
  wire sclk_fall = frame_on & ~sclk_s2_r & sclk_s3_r;

  // ---------------- Serial port ----------------
  logic [5:0] bit_cnt_r;
  logic [15:0] shift_in_r;
  logic [31:0] shift_out_r;
  logic started_r;
  logic sout_r;
  logic new_data_r;
  logic [15:0] conv_r;
  wire [15:0] in_word = {shift_in_r[14:0], din_s2_r};

  // Config is taken after the 16th bit, only when marked valid
  assign cfg_wr_word = amc_cfg_t'(in_word);
  assign cfg_wr = sclk_fall && (bit_cnt_r == 6'h0F)
                  && (cfg_wr_word.nop == `AMC_NOP_VALID);

  // Input bits are sampled on the falling serial edge
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || !frame_on)
    begin
      bit_cnt_r <= 6'h00;
      shift_in_r <= 16'h0000;
    end
    else if (sclk_fall)
    begin
      shift_in_r <= in_word;
      bit_cnt_r <= bit_cnt_r + 6'h01;
    end
  end

  // Result is locked at the first rising edge and shifted MSB first
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || !frame_on)
    begin
      started_r <= 1'h0;
      shift_out_r <= 32'h0000_0000;
      sout_r <= 1'h1;
    end
    else if (sclk_rise && !started_r)
    begin
      started_r <= 1'h1;
      shift_out_r <= {conv_r[14:0], cfg_r, 1'h0};
      sout_r <= conv_r[15];
    end
    else if (sclk_rise)
    begin
      shift_out_r <= {shift_out_r[30:0], 1'h0};
      sout_r <= shift_out_r[31];
    end
    else if (cfg_wr)
      shift_out_r[31:16] <= {1'h0, in_word[14:0]}; // Readback of the new word
    else if (!started_r)
      sout_r <= ~new_data_r;
  end

  // Pin floats while deselected; the pull-up enable goes out separately
  assign o_serial_out_result_ready = sout_r;
  assign o_serial_out_result_ready_oe = frame_on;

  // ---------------- Oscillator and sequencer ----------------
  logic [6:0] osc_div_r;
  logic osc_tick;
  amc_state_t state_r, state_nxt;
  logic [16:0] tick_cnt_r;
  logic [16:0] period_r;
  logic conv_temp_r;
  logic buf_in_ready;
  logic buf_out_valid;
  amc_result_t buf_out_data;
  amc_result_t result_word;

  // Internal 1 MHz tick from the core clock; no external converter clock
  assign osc_tick = (osc_div_r == 7'(P_OSC_DIV - 1));

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || osc_tick)
      osc_div_r <= 7'h00;
    else
      osc_div_r <= osc_div_r + 7'h01;
  end

  wire in_pwrdn = (state_r == AMC_ST_PWRDN);
  wire single_mode = (cfg_r.mode == `AMC_MODE_SINGLE);
  // A start request counts only while idle in single-shot mode
  wire ss_start = cfg_wr && cfg_wr_word.ss && in_pwrdn
                  && (cfg_wr_word.mode == `AMC_MODE_SINGLE);
  wire cont_start = in_pwrdn && !single_mode && !cfg_wr;
  wire conv_end = (state_r == AMC_ST_CONV) && osc_tick
                  && (tick_cnt_r == period_r - 17'h00001);
  // In continuous mode, ready goes high again shortly before an unread next result
  wire early_clr = (state_r == AMC_ST_CONV) && !single_mode && osc_tick
                   && (tick_cnt_r == period_r - 17'(`AMC_DRDY_EARLY_TICKS) - 17'h00001);

  // Next state of the mode sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      AMC_ST_PWRDN:
        if (ss_start || cont_start)
          state_nxt = AMC_ST_CONV;
      AMC_ST_CONV:
        if (conv_end)
          state_nxt = AMC_ST_DONE;
      AMC_ST_DONE:
        if (buf_in_ready)
          state_nxt = single_mode ? AMC_ST_PWRDN : AMC_ST_CONV;
      default:
        state_nxt = AMC_ST_PWRDN;
    endcase
  end

  // Sequencer, conversion timer and per-conversion settings
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      state_r <= AMC_ST_PWRDN;
      tick_cnt_r <= 17'h00000;
      period_r <= `AMC_TICKS_860SPS;
      conv_temp_r <= 1'h0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_nxt == AMC_ST_CONV && state_r != AMC_ST_CONV)
      begin
        tick_cnt_r <= 17'h00000;
        period_r <= rate_ticks(cfg_wr ? cfg_wr_word.rate : cfg_r.rate);
        conv_temp_r <= cfg_wr ? cfg_wr_word.temp_sel : cfg_r.temp_sel;
      end
      else if (state_r == AMC_ST_CONV && osc_tick)
        tick_cnt_r <= tick_cnt_r + 17'h00001;
    end
  end

  assign o_powered_up = !in_pwrdn;
  assign o_temp_sensor_select = conv_temp_r;
  assign o_conv_done = (state_r == AMC_ST_DONE) && buf_in_ready;

  // Temp code left-justified; input code clipped at full scale
  assign result_word.from_temp = conv_temp_r;
  assign result_word.code = conv_temp_r ? {i_temp_code, 2'h0}
                                        : sat16(i_mod_result);

  // Finished results wait here while a read holds the register
  amc_pair_buf #(
    .W($bits(amc_result_t))
  ) u_result_buf (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_in_valid(state_r == AMC_ST_DONE),
    .o_in_ready(buf_in_ready),
    .i_in_data(result_word),
    .o_out_valid(buf_out_valid),
    .i_out_ready(!started_r),
    .o_out_data(buf_out_data)
  );

  wire load_conv = buf_out_valid && !started_r;

  // Conversion register; new result wins over any clear of the ready flag
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      conv_r <= 16'h0000;
      new_data_r <= 1'h0;
    end
    else if (load_conv)
    begin
      conv_r <= buf_out_data.code;
      new_data_r <= 1'h1;
    end
    else if ((sclk_rise && !started_r) || early_clr)
      new_data_r <= 1'h0;
  end

endmodule : amc_mode_ctrl

/* amc_regs.svh */
// Constants for the converter mode control block: config field positions,
// reset values and timing counts. Assumes a 100 MHz core clock.
`ifndef AMC_REGS_SVH
`define AMC_REGS_SVH

// Config word field positions
`define AMC_CFG_SS_BIT 15
`define AMC_CFG_MUX_HI 14
`define AMC_CFG_MUX_LO 12
`define AMC_CFG_GAIN_HI 11
`define AMC_CFG_GAIN_LO 9
`define AMC_CFG_MODE_BIT 8
`define AMC_CFG_RATE_HI 7
`define AMC_CFG_RATE_LO 5
`define AMC_CFG_TEMP_BIT 4
`define AMC_CFG_PULLUP_BIT 3
`define AMC_CFG_NOP_HI 2
`define AMC_CFG_NOP_LO 1

// Reset value of the config word and the write-valid marker
`define AMC_CFG_RESET 16'h058B
`define AMC_NOP_VALID 2'h1
`define AMC_MODE_SINGLE 1'h1
`define AMC_MODE_CONT 1'h0

// Clock rates and derived oscillator divider
`define AMC_CORE_FREQ_KHZ 100000
`define AMC_OSC_FREQ_KHZ 1000
`define AMC_OSC_DIV (`AMC_CORE_FREQ_KHZ / `AMC_OSC_FREQ_KHZ)

// Early data-ready release before the next result, in oscillator ticks
`define AMC_DRDY_EARLY_US 8
`define AMC_DRDY_EARLY_TICKS (`AMC_DRDY_EARLY_US * `AMC_OSC_FREQ_KHZ / 1000)

// Oscillator ticks per conversion for each data rate code
`define AMC_TICKS_8SPS 17'h1E848
`define AMC_TICKS_16SPS 17'h0F424
`define AMC_TICKS_32SPS 17'h07A12
`define AMC_TICKS_64SPS 17'h03D09
`define AMC_TICKS_128SPS 17'h01E85
`define AMC_TICKS_250SPS 17'h00FA0
`define AMC_TICKS_475SPS 17'h00839
`define AMC_TICKS_860SPS 17'h0048B

// Full-scale spans in millivolts and LSB size per 256 mV of span
`define AMC_SPAN_6144MV 13'h1800
`define AMC_SPAN_4096MV 13'h1000
`define AMC_SPAN_2048MV 13'h0800
`define AMC_SPAN_1024MV 13'h0400
`define AMC_SPAN_512MV 13'h0200
`define AMC_SPAN_256MV 13'h0100
`define AMC_LSB_PV_PER_256MV 28'h0773594

// Saturation codes of an input result
`define AMC_CODE_POS_FULL 16'h7FFF
`define AMC_CODE_NEG_FULL 16'h8000

`endif

/* amc_pkg.sv */
// Types shared by the converter mode control block.
// Assumes amc_regs.svh supplies the numeric constants.
package amc_pkg;

  // Config word as stored and read back
  typedef struct packed {
    logic ss;
    logic [2:0] mux;
    logic [2:0] gain;
    logic mode;
    logic [2:0] rate;
    logic temp_sel;
    logic pullup_en;
    logic [1:0] nop;
    logic rsvd;
  } amc_cfg_t;

  // One finished conversion on its way to the conversion register
  typedef struct packed {
    logic from_temp;
    logic [15:0] code;
  } amc_result_t;

  // Mode sequencer states, one-hot
  typedef enum logic [2:0] {
    AMC_ST_PWRDN = 3'h1,
    AMC_ST_CONV = 3'h2,
    AMC_ST_DONE = 3'h4
  } amc_state_t;

endpackage : amc_pkg

/* amc_pair_buf.sv */
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module amc_pair_buf #(
  parameter int W = 17
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);

  logic [W-1:0] mem_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] count_r;
  wire push = i_in_valid & o_in_ready;
  wire pop = o_out_valid & i_out_ready;

  // Honest full and empty from the occupancy count
  assign o_in_ready = (count_r != 2'h2);
  assign o_out_valid = (count_r != 2'h0);
  assign o_out_data = mem_r[rd_ptr_r];

  // Storage and pointers
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      wr_ptr_r <= 1'h0;
      rd_ptr_r <= 1'h0;
      count_r <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem_r[wr_ptr_r] <= i_in_data;
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
      count_r <= count_r + {1'h0, push} - {1'h0, pop};
    end
  end

endmodule : amc_pair_buf

/* amc_monitor.sv */
// Port checker for the converter mode control block.
// Assumes it is bound into every amc_mode_ctrl instance.
module amc_monitor
  import amc_pkg::*;
#(
  parameter int P_OSC_DIV = 100
) (
  // Clock, reset and select
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  // Watched outputs
  input wire logic o_serial_out_result_ready_oe,
  input wire logic o_sout_pullup_en,
  input wire logic [2:0] o_gain_range_select,
  input wire logic [12:0] o_full_scale_span,
  input wire logic [27:0] o_lsb_size_pv,
  input wire logic o_temp_sensor_select,
  input wire logic o_powered_up,
  input wire logic o_conv_done
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  localparam int MIN_CONV = 1100 * P_OSC_DIV;
  logic [17:0] busy_r;
  logic [17:0] busy_nxt;
  wire [12:0] span_exp;
  wire [27:0] lsb_exp;
  wire [2:0] g = o_gain_range_select;
  // Held while idle so a late done pulse never sees a cleared count
  assign busy_nxt = o_conv_done ? 18'h00000 : (o_powered_up ? busy_r + 18'h00001 : busy_r);
  always_ff @(posedge i_core_clk)
  begin
    busy_r <= i_rst ? 18'h00000 : busy_nxt;
  end
  // Codes above five all give the narrowest span
  assign span_exp = (g == 3'h0) ? 13'h1800 : (g > 3'h5) ? 13'h0100 : 13'h1000 >> (g - 3'h1);
  assign lsb_exp = (g == 3'h0) ? 28'hB2D05E0 : (g > 3'h5) ? 28'h0773594 :
    28'h7735940 >> (g - 3'h1);
  sequence s_cs_idle;
    i_cs_n [*3];
  endsequence
  sequence s_cs_sel;
    !i_cs_n [*3];
  endsequence
  AST_RST_CFG: assert property ($fell(i_rst) |-> g == 3'h2 && o_sout_pullup_en)
    else $error("config not at default after reset");
  AST_RST_PWRDN: assert property ($fell(i_rst) |-> !o_powered_up && !o_conv_done)
    else $error("not powered down after reset");
  AST_SPAN: assert property ($stable(g) && !$past(i_rst) |-> o_full_scale_span == span_exp)
    else $error("span does not match gain code");
  AST_LSB: assert property ($stable(g) && !$past(i_rst) |-> o_lsb_size_pv == lsb_exp)
    else $error("lsb size does not match gain code");
  AST_OE_OFF: assert property (s_cs_idle |-> !o_serial_out_result_ready_oe)
    else $error("pin driven while deselected");
  AST_OE_ON: assert property (s_cs_sel |-> o_serial_out_result_ready_oe)
    else $error("pin not driven while selected");
  AST_DONE_PULSE: assert property (o_conv_done |=> !o_conv_done)
    else $error("done pulse longer than one cycle");
  AST_CONV_LEN: assert property (o_conv_done |-> busy_r > MIN_CONV)
    else $error("conversion ended too early");
  AST_TEMP_HOLD: assert property (!o_powered_up && !$past(o_powered_up) && !$past(i_rst)
    |-> $stable(o_temp_sensor_select))
    else $error("temp select changed while idle");
endmodule : amc_monitor

bind amc_mode_ctrl amc_monitor #(.P_OSC_DIV(P_OSC_DIV)) amc_monitor_inst (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_cs_n(i_cs_n),
  .o_serial_out_result_ready_oe(o_serial_out_result_ready_oe),
  .o_sout_pullup_en(o_sout_pullup_en), .o_gain_range_select(o_gain_range_select),
  .o_full_scale_span(o_full_scale_span), .o_lsb_size_pv(o_lsb_size_pv),
  .o_temp_sensor_select(o_temp_sensor_select), .o_powered_up(o_powered_up),
  .o_conv_done(o_conv_done));

/* amc_host_model.sv */
// Host serial master model for the converter's serial port.
// Assumes the bench calls frame() one at a time.
module amc_host_model (
  // Serial pins toward the device
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din,
  // Pin as driven by the device
  input wire logic i_sout,
  input wire logic i_sout_oe,
  input wire logic i_pullup_en
);
  timeunit 1ns;
  timeprecision 10ps; // Fine enough that the 31.25 ns quarter steps stay exact
  logic last_r;
  wire pin_lvl;
  // Released pin: pull-up if enabled, else never the stale bit
  assign pin_lvl = i_sout_oe ? i_sout : (i_pullup_en ? 1'b1 : ~last_r);
  always @(i_sout) if (i_sout_oe) last_r = i_sout;
  initial
  begin
    last_r = 1'b0;
    o_cs_n = 1'b1;
    o_sclk = 1'b0; // Clock rests low between frames
    o_din = 1'b0;
  end
  // One frame MSB first, 125 ns clock; host picks the spacing freely
  task automatic frame(input logic [31:0] word, input int nbits, output logic [31:0] rx,
    output logic rdy_n);
    int i;
    rx = 32'h0;
    o_cs_n = 1'b0;
    #300 rdy_n = pin_lvl;
    for (i = nbits - 1; i >= 0; i--)
    begin
      #31.25 o_din = word[i]; // Held across the falling edge
      #31.25 o_sclk = 1'b1;
      #62.5 rx[i] = pin_lvl; // Shifted on the rise, read late
      o_sclk = 1'b0;
    end
    #300 o_cs_n = 1'b1;
    o_din = ~o_din;
    #400;
  endtask : frame
endmodule : amc_host_model

/* tb.sv */
// Self-checking bench for the converter mode control block.
// Assumes P_OSC_DIV of 1, so one oscillator tick per core cycle.
`define CHK(nm, exp, got) \
  begin checks++; if ((got) !== (exp)) begin err_count++; \
  $display("ERROR %s exp %0h got %0h", nm, exp, got); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import amc_pkg::*;
  logic clk = 1'b0;
  logic rst, cs_n, sclk, din, sout, oe, pu, tsel, pwr, done, rdy;
  logic [17:0] mod_result;
  logic [13:0] temp_code;
  logic [2:0] gain;
  logic [2:0] mux;
  logic [12:0] span;
  logic [27:0] lsb;
  logic [31:0] rx;
  int err_count = 0;
  int checks = 0;
  int n;
  time t_on;
  logic [27:0] lsb_tab [6] = '{28'hB2D05E0, 28'h7735940, 28'h3B9ACA0, 28'h1DCD650,
    28'h0EE6B28, 28'h0773594};
  // Core clock and conversion start stamp
  always #5 clk = ~clk;
  always @(posedge pwr) t_on = $time;
  amc_mode_ctrl #(.P_OSC_DIV(1)) amc_mode_ctrl_inst (.i_core_clk(clk), .i_rst(rst),
    .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din), .o_serial_out_result_ready(sout),
    .o_serial_out_result_ready_oe(oe), .o_sout_pullup_en(pu), .i_mod_result(mod_result),
    .i_temp_code(temp_code), .o_gain_range_select(gain), .o_full_scale_span(span),
    .o_lsb_size_pv(lsb), .o_input_mux(mux), .o_temp_sensor_select(tsel),
    .o_powered_up(pwr), .o_conv_done(done));
  amc_host_model amc_host_model_inst (.o_cs_n(cs_n), .o_sclk(sclk), .o_din(din),
    .i_sout(sout), .i_sout_oe(oe), .i_pullup_en(pu));
  // Config word at 860 SPS with the write marker set
  function automatic logic [15:0] cfgw(logic ss, logic [2:0] g, logic md, logic tp);
    return {ss, 3'h0, g, md, 3'h7, tp, 1'b1, 2'h1, 1'b0};
  endfunction : cfgw
  task automatic conclude();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic wr(input logic [15:0] w);
    amc_host_model_inst.frame({16'h0, w}, 16, rx, rdy);
    @(negedge clk);
  endtask : wr
  // Bounded wait for the next result pulse
  task automatic wait_done(output int cnt);
    cnt = 0;
    @(negedge clk);
    while (done !== 1'b1)
    begin
      @(negedge clk);
      cnt++;
      if (cnt > 3000)
      begin
        err_count++;
        conclude();
      end
    end
  endtask : wait_done
  // One single-shot with a second start request ignored mid-way
  task automatic shot(input logic tp, input logic [17:0] mr, input logic [13:0] tc,
    input logic [15:0] exp);
    @(negedge clk);
    mod_result = mr;
    temp_code = tc;
    wr(cfgw(1'b1, 3'h2, 1'b1, tp));
    `CHK("pwr_on", 1'b1, pwr)
    `CHK("tsel", tp, tsel)
    wr(cfgw(1'b1, 3'h2, 1'b1, tp));
    wait_done(n);
    `CHK("len", 1'b1, ($time - t_on) / 10 inside {[1162:1170]})
    repeat (5) @(negedge clk);
    `CHK("pwr_off", 1'b0, pwr)
    amc_host_model_inst.frame(32'h0, 16, rx, rdy);
    `CHK("rdy", 1'b0, rdy)
    `CHK("code", exp, rx[15:0])
    repeat (1200) @(negedge clk);
    `CHK("no_requeue", 1'b0, pwr)
  endtask : shot
  initial
  begin
    rst = 1'b1;
    mod_result = 18'h00000;
    temp_code = 14'h0000;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK("pwr_rst", 1'b0, pwr)
    `CHK("span_rst", 13'h0800, span)
    amc_host_model_inst.frame(32'h0, 32, rx, rdy);
    `CHK("readback", 16'h058B, rx[15:0])
    `CHK("conv_rst", 16'h0000, rx[31:16])
    for (int g = 0; g < 6; g++)
    begin
      wr(cfgw(1'b0, g[2:0], 1'b1, 1'b0) | {1'b0, g[2:0], 12'h000});
      `CHK("gain", g[2:0], gain)
      `CHK("mux", g[2:0], mux)
      `CHK("lsb", lsb_tab[g], lsb)
      `CHK("pwr_idle", 1'b0, pwr)
    end
    shot(1'b0, 18'h00123, 14'h0000, 16'h0123);
    shot(1'b0, 18'h0FFFF, 14'h0000, 16'h7FFF);
    shot(1'b0, 18'h30000, 14'h0000, 16'h8000);
    shot(1'b1, 18'h00123, 14'h3CE0, 16'hF380);
    amc_host_model_inst.frame(32'h0, 16, rx, rdy);
    `CHK("rdy_clr", 1'b1, rdy)
    // Rate code 6 must pace a longer conversion than the fastest code
    wr(cfgw(1'b1, 3'h2, 1'b1, 1'b0) & ~16'h0020);
    wait_done(n);
    `CHK("len_r6", 1'b1, ($time - t_on) / 10 inside {[2104:2112]})
    // Continuous run, then leave it by the mode bit
    wr(cfgw(1'b0, 3'h2, 1'b0, 1'b0));
    wait_done(n);
    wait_done(n);
    `CHK("cont_gap", 1'b1, n inside {[1162:1170]})
    `CHK("pwr_cont", 1'b1, pwr)
    wr(cfgw(1'b0, 3'h2, 1'b1, 1'b0));
    wait_done(n);
    repeat (5) @(negedge clk);
    `CHK("pwr_left", 1'b0, pwr)
    // Continuous again, then leave it by a reset right after a result pulse
    wr(cfgw(1'b0, 3'h5, 1'b0, 1'b0));
    wait_done(n);
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK("gain_rst2", 3'h2, gain)
    repeat (1300) @(negedge clk);
    `CHK("pwr_rst2", 1'b0, pwr)
    conclude();
  end
endmodule : tb
